// >>> src/tsxyg_pkg.sv
package tsxyg_pkg;

	// Register byte offsets on the APB bus.
	localparam logic [7:0] OFS_FE_C   = 8'h00;
	localparam logic [7:0] OFS_FE_D   = 8'h04;
	localparam logic [7:0] OFS_XY     = 8'h08;
	localparam logic [7:0] OFS_ONE    = 8'h0C;
	localparam logic [7:0] OFS_MULTI  = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;

	// Writable bits of each register; the others read as zero.
	localparam logic [7:0] MASK_FE_C  = 8'hFF;
	localparam logic [7:0] MASK_FE_D  = 8'h77;
	localparam logic [7:0] MASK_XY    = 8'h0F;
	localparam logic [7:0] MASK_ONE   = 8'h3F;
	localparam logic [7:0] MASK_MULTI = 8'h07;

	// Reset values.
	localparam logic [7:0] RST_FE_C  = 8'h00;
	localparam logic [7:0] RST_FE_D  = 8'h00;
	localparam logic [7:0] RST_XY    = 8'h00;
	localparam logic [7:0] RST_ONE   = 8'h00;
	localparam logic [7:0] RST_MULTI = 8'h00;

	// Field positions.
	localparam int SETTLE_MSB = 7;
	localparam int SETTLE_LSB = 6;
	localparam int TRIP_MSB   = 3;
	localparam int TRIP_LSB   = 0;
	localparam int CHARGE_MSB = 6;
	localparam int CHARGE_LSB = 4;
	localparam int XFER_MSB   = 2;
	localparam int XFER_LSB   = 0;
	localparam int PALM_BIT   = 3;
	localparam int SWAP_BIT   = 2;
	localparam int FLIPY_BIT  = 1;
	localparam int FLIPX_BIT  = 0;
	localparam int ONE_W      = 6;
	localparam int MULTI_W    = 3;
	localparam int COORD_W    = 16;

	// Settle times and the clock period.
	localparam int unsigned CLK_PERIOD_NS   = 20;
	localparam int unsigned SETTLE_LONG_NS  = 1700000;
	localparam int unsigned SETTLE_MID_NS   = 500000;
	localparam int unsigned SETTLE_SHORT_NS = 120000;

	typedef enum logic [1:0] {
		SETTLE_LONG  = 2'b00,
		SETTLE_MID   = 2'b01,
		SETTLE_SHORT = 2'b10,
		SETTLE_RSVD  = 2'b11
	} tsxyg_settle_t;

	typedef struct packed {
		logic [7:0] fe_c;
		logic [7:0] fe_d;
		logic [7:0] xy;
		logic [7:0] one;
		logic [7:0] multi;
	} tsxyg_cfg_t;

	typedef struct packed {
		logic [COORD_W-1:0] x;
		logic [COORD_W-1:0] y;
	} tsxyg_xy_t;

	typedef struct packed {
		logic [ONE_W-1:0]   one;
		logic [MULTI_W-1:0] multi;
	} tsxyg_gest_t;

endpackage : tsxyg_pkg

// >>> src/tsxyg_settle_timer.sv
`timescale 1ns/100ps
`default_nettype none
module tsxyg_settle_timer #(
	parameter int unsigned LONG_CYC  = 85000,
	parameter int unsigned MID_CYC   = 25000,
	parameter int unsigned SHORT_CYC = 6000
) (
	// Clock and reset.
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	// Control.
	input  wire logic                     start,
	input  wire tsxyg_pkg::tsxyg_settle_t sel,
	// Status.
	output logic                          busy,
	output logic                          done
);

	localparam int CNT_W = $clog2(LONG_CYC + 1);

	typedef struct packed {
		logic             busy;
		logic             done;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] len;
		logic [CNT_W-1:0] elapsed;
	} tsxyg_tmr_st_t;

	tsxyg_tmr_st_t st_r, st_nxt;
	logic [CNT_W-1:0] len_sel;

	always_comb begin
		// The reserved code falls back to the longest delay, so it never shortens settling.
		case (sel)
			tsxyg_pkg::SETTLE_MID:   len_sel = CNT_W'(MID_CYC);
			tsxyg_pkg::SETTLE_SHORT: len_sel = CNT_W'(SHORT_CYC);
			default:                 len_sel = CNT_W'(LONG_CYC);
		endcase
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		if (start) begin
			st_nxt.busy = 1'b1;
			st_nxt.len = len_sel;
			st_nxt.cnt = len_sel - 1'b1;
			st_nxt.elapsed = '0;
		end else if (st_r.busy) begin
			st_nxt.elapsed = st_r.elapsed + 1'b1;
			if (st_r.cnt == '0) begin
				st_nxt.busy = 1'b0;
				st_nxt.done = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign busy = st_r.busy;
	assign done = st_r.done;

	if (LONG_CYC < 1 || MID_CYC < 1 || SHORT_CYC < 1 || MID_CYC > LONG_CYC
			|| SHORT_CYC > LONG_CYC) begin : g_chk
		$error("settle counts must be at least one and not above the long count");
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_settle_len: assert property (st_r.done |-> st_r.elapsed == st_r.len)
		else $error("settle delay length differs from selected code");
	a_settle_load: assert property (start |=> st_r.busy && st_r.len == $past(len_sel))
		else $error("settle timer did not load selected delay");

endmodule : tsxyg_settle_timer
`default_nettype wire

// >>> src/tsxyg_xy_map.sv
`timescale 1ns/100ps
`default_nettype none
module tsxyg_xy_map (
	// Clock and reset.
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	// Active XY configuration byte.
	input  wire logic [7:0]                    xy_cfg,
	// Raw position in.
	input  wire logic                          in_valid,
	input  wire logic [tsxyg_pkg::COORD_W-1:0] rx_pos,
	input  wire logic [tsxyg_pkg::COORD_W-1:0] tx_pos,
	input  wire logic [tsxyg_pkg::COORD_W-1:0] span_x,
	input  wire logic [tsxyg_pkg::COORD_W-1:0] span_y,
	input  wire logic                          palm_detect,
	// Mapped position out.
	output logic                               out_valid,
	output tsxyg_pkg::tsxyg_xy_t               out_pos
);

	typedef struct packed {
		logic                 valid;
		tsxyg_pkg::tsxyg_xy_t pos;
	} tsxyg_map_st_t;

	tsxyg_map_st_t st_r, st_nxt;
	logic [tsxyg_pkg::COORD_W-1:0] sx, sy;

	always_comb begin
		sx = xy_cfg[tsxyg_pkg::SWAP_BIT] ? tx_pos : rx_pos;
		sy = xy_cfg[tsxyg_pkg::SWAP_BIT] ? rx_pos : tx_pos;
		st_nxt = st_r;
		st_nxt.valid = in_valid && !(xy_cfg[tsxyg_pkg::PALM_BIT] && palm_detect);
		if (in_valid) begin
			// Positions past the span invert to zero rather than wrapping.
			if (!xy_cfg[tsxyg_pkg::FLIPX_BIT]) begin
				st_nxt.pos.x = sx;
			end else begin
				st_nxt.pos.x = (sx > span_x) ? '0 : span_x - sx;
			end
			if (!xy_cfg[tsxyg_pkg::FLIPY_BIT]) begin
				st_nxt.pos.y = sy;
			end else begin
				st_nxt.pos.y = (sy > span_y) ? '0 : span_y - sy;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign out_valid = st_r.valid;
	assign out_pos   = st_r.pos;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_palm_block: assert property (in_valid && palm_detect && xy_cfg[3] |=> !out_valid)
		else $error("palm contact reached the XY output");
	a_axis_swap: assert property (in_valid && xy_cfg[2:0] == 3'b100 |=>
			out_pos.x == $past(tx_pos) && out_pos.y == $past(rx_pos))
		else $error("axis swap not applied");
	a_flip_y: assert property (in_valid && xy_cfg[2:1] == 2'b01 && rx_pos <= span_y
			|=> out_pos.y == $past(span_y) - $past(tx_pos) || $past(tx_pos) > $past(span_y))
		else $error("Y inversion not applied");
	a_flip_x: assert property (in_valid && xy_cfg[2] == 1'b0 && xy_cfg[0]
			|=> out_pos.x == $past(span_x) - $past(rx_pos) || $past(rx_pos) > $past(span_x))
		else $error("X inversion not applied");

endmodule : tsxyg_xy_map
`default_nettype wire

// >>> src/tsxyg_top.sv
`timescale 1ns/100ps
`default_nettype none
module tsxyg_top #(
	parameter int unsigned SETTLE_LONG_CYC  = (tsxyg_pkg::SETTLE_LONG_NS
		+ tsxyg_pkg::CLK_PERIOD_NS - 1) / tsxyg_pkg::CLK_PERIOD_NS,
	parameter int unsigned SETTLE_MID_CYC   = (tsxyg_pkg::SETTLE_MID_NS
		+ tsxyg_pkg::CLK_PERIOD_NS - 1) / tsxyg_pkg::CLK_PERIOD_NS,
	parameter int unsigned SETTLE_SHORT_CYC = (tsxyg_pkg::SETTLE_SHORT_NS
		+ tsxyg_pkg::CLK_PERIOD_NS - 1) / tsxyg_pkg::CLK_PERIOD_NS
) (
	// Clock and reset.
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	// APB slave.
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [7:0]                    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic [31:0]                        prdata,
	output logic                               pready,
	output logic                               pslverr,
	// Sensing front end.
	input  wire logic                          cycle_start,
	output logic                               settle_busy,
	output logic                               conv_start,
	output logic [3:0]                         trip_level_code,
	output logic [2:0]                         charge_phase_length,
	output logic [2:0]                         transfer_phase_length,
	// XY path.
	input  wire logic                          xy_in_valid,
	input  wire logic [tsxyg_pkg::COORD_W-1:0] xy_rx_pos,
	input  wire logic [tsxyg_pkg::COORD_W-1:0] xy_tx_pos,
	input  wire logic [tsxyg_pkg::COORD_W-1:0] span_x,
	input  wire logic [tsxyg_pkg::COORD_W-1:0] span_y,
	input  wire logic                          palm_detect,
	output logic                               xy_out_valid,
	output tsxyg_pkg::tsxyg_xy_t               xy_out,
	// Gesture path.
	input  wire logic                          gest_in_valid,
	input  wire tsxyg_pkg::tsxyg_gest_t        gest_in,
	output logic                               gest_out_valid,
	output tsxyg_pkg::tsxyg_gest_t             gest_out
);

	typedef struct packed {
		tsxyg_pkg::tsxyg_cfg_t  cfg;
		tsxyg_pkg::tsxyg_cfg_t  act;
		logic [31:0]            rdata;
		logic                   slverr;
		logic                   palm_hold;
		logic                   gest_vld;
		tsxyg_pkg::tsxyg_gest_t gest;
	} tsxyg_top_st_t;

	tsxyg_top_st_t          st_r, st_nxt;
	logic                   setup_ph;
	logic                   wr_acc;
	logic                   rd_hit;
	logic [31:0]            rd_word;
	logic [7:0]             wbyte;
	logic                   cfg_pending;
	tsxyg_pkg::tsxyg_gest_t gated;

	assign setup_ph    = psel && !penable;
	assign wr_acc      = psel && penable && pwrite;
	assign wbyte       = pwdata[7:0];
	assign cfg_pending = st_r.cfg != st_r.act;

	// Read decode; an unmapped address reads zero and answers with an error.
	always_comb begin
		rd_hit = 1'b1;
		rd_word = 32'h0000_0000;
		if (paddr == tsxyg_pkg::OFS_FE_C) begin
			rd_word[7:0] = st_r.cfg.fe_c;
		end else if (paddr == tsxyg_pkg::OFS_FE_D) begin
			rd_word[7:0] = st_r.cfg.fe_d;
		end else if (paddr == tsxyg_pkg::OFS_XY) begin
			rd_word[7:0] = st_r.cfg.xy;
		end else if (paddr == tsxyg_pkg::OFS_ONE) begin
			rd_word[7:0] = st_r.cfg.one;
		end else if (paddr == tsxyg_pkg::OFS_MULTI) begin
			rd_word[7:0] = st_r.cfg.multi;
		end else if (paddr == tsxyg_pkg::OFS_STATUS) begin
			rd_word[2:0] = {cfg_pending, st_r.palm_hold, settle_busy};
		end else begin
			rd_hit = 1'b0;
		end
	end

	// Gestures are masked with the enables of the running sensing cycle.
	assign gated.one   = gest_in.one & st_r.act.one[tsxyg_pkg::ONE_W-1:0];
	assign gated.multi = gest_in.multi & st_r.act.multi[tsxyg_pkg::MULTI_W-1:0];

	always_comb begin
		st_nxt = st_r;
		// Answer data is captured in the setup cycle so the access cycle needs no wait.
		if (setup_ph) begin
			st_nxt.rdata = pwrite ? 32'h0000_0000 : rd_word;
			st_nxt.slverr = !rd_hit;
		end
		// Writes to the status word and unmapped offsets change nothing.
		if (wr_acc) begin
			if (paddr == tsxyg_pkg::OFS_FE_C) begin
				st_nxt.cfg.fe_c = wbyte & tsxyg_pkg::MASK_FE_C;
			end else if (paddr == tsxyg_pkg::OFS_FE_D) begin
				st_nxt.cfg.fe_d = wbyte & tsxyg_pkg::MASK_FE_D;
			end else if (paddr == tsxyg_pkg::OFS_XY) begin
				st_nxt.cfg.xy = wbyte & tsxyg_pkg::MASK_XY;
			end else if (paddr == tsxyg_pkg::OFS_ONE) begin
				st_nxt.cfg.one = wbyte & tsxyg_pkg::MASK_ONE;
			end else if (paddr == tsxyg_pkg::OFS_MULTI) begin
				st_nxt.cfg.multi = wbyte & tsxyg_pkg::MASK_MULTI;
			end
		end
		// A write in the start cycle reaches cfg but misses this copy and waits for the next cycle start.
		if (cycle_start) begin
			st_nxt.act = st_r.cfg;
		end
		st_nxt.palm_hold = palm_detect && st_r.act.xy[tsxyg_pkg::PALM_BIT];
		st_nxt.gest_vld = gest_in_valid && (gated != '0);
		st_nxt.gest = gest_in_valid ? gated : '0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
			st_r.cfg.fe_c <= tsxyg_pkg::RST_FE_C;
			st_r.cfg.fe_d <= tsxyg_pkg::RST_FE_D;
			st_r.cfg.xy <= tsxyg_pkg::RST_XY;
			st_r.cfg.one <= tsxyg_pkg::RST_ONE;
			st_r.cfg.multi <= tsxyg_pkg::RST_MULTI;
			st_r.act.fe_c <= tsxyg_pkg::RST_FE_C;
			st_r.act.fe_d <= tsxyg_pkg::RST_FE_D;
			st_r.act.xy <= tsxyg_pkg::RST_XY;
			st_r.act.one <= tsxyg_pkg::RST_ONE;
			st_r.act.multi <= tsxyg_pkg::RST_MULTI;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pready = 1'b1;
	assign prdata = st_r.rdata;
	assign pslverr = st_r.slverr;
	assign trip_level_code = st_r.act.fe_c[tsxyg_pkg::TRIP_MSB:tsxyg_pkg::TRIP_LSB];
	assign charge_phase_length =
		st_r.act.fe_d[tsxyg_pkg::CHARGE_MSB:tsxyg_pkg::CHARGE_LSB];
	assign transfer_phase_length =
		st_r.act.fe_d[tsxyg_pkg::XFER_MSB:tsxyg_pkg::XFER_LSB];
	assign gest_out_valid = st_r.gest_vld;
	assign gest_out = st_r.gest;

	// The settle code is read from the register that becomes active at this same edge.
	tsxyg_settle_timer #(
		.LONG_CYC  (SETTLE_LONG_CYC),
		.MID_CYC   (SETTLE_MID_CYC),
		.SHORT_CYC (SETTLE_SHORT_CYC)
	) u_settle (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (cycle_start),
		.sel     (tsxyg_pkg::tsxyg_settle_t'(
			st_r.cfg.fe_c[tsxyg_pkg::SETTLE_MSB:tsxyg_pkg::SETTLE_LSB])),
		.busy    (settle_busy),
		.done    (conv_start)
	);

	tsxyg_xy_map u_xy (
		.pclk        (pclk),
		.presetn     (presetn),
		.xy_cfg      (st_r.act.xy),
		.in_valid    (xy_in_valid),
		.rx_pos      (xy_rx_pos),
		.tx_pos      (xy_tx_pos),
		.span_x      (span_x),
		.span_y      (span_y),
		.palm_detect (palm_detect),
		.out_valid   (xy_out_valid),
		.out_pos     (xy_out)
	);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_trip_follow: assert property (cycle_start |=>
			trip_level_code == $past(st_r.cfg.fe_c[3:0]))
		else $error("trip code not taken at cycle start");
	a_phase_follow: assert property (cycle_start |=>
			{charge_phase_length, transfer_phase_length} ==
			{$past(st_r.cfg.fe_d[6:4]), $past(st_r.cfg.fe_d[2:0])})
		else $error("phase lengths not taken at cycle start");
	a_unused_zero: assert property (setup_ph && !pwrite && paddr == tsxyg_pkg::OFS_FE_D
			|=> prdata[7] == 1'b0 && prdata[3] == 1'b0)
		else $error("unused front-end D bits read as one");
	// The output was masked with the enables of the cycle before, which a start may have replaced.
	a_swipe_gate: assert property (gest_out_valid |->
			(gest_out.one[5:2] & ~$past(st_r.act.one[5:2])) == 4'h0)
		else $error("disabled swipe reported");
	a_tap_gate: assert property (gest_out_valid |->
			(gest_out.one[1:0] & ~$past(st_r.act.one[1:0])) == 2'h0)
		else $error("disabled tap or hold reported");
	a_multi_gate: assert property (gest_out_valid |->
			(gest_out.multi & ~$past(st_r.act.multi[2:0])) == 3'h0)
		else $error("disabled multi-finger gesture reported");
	a_gest_idle: assert property (!gest_out_valid |-> gest_out == '0)
		else $error("gesture output not cleared while idle");
	a_phase_mask: assert property (wr_acc && paddr == tsxyg_pkg::OFS_FE_D |=>
			(st_r.cfg.fe_d & ~tsxyg_pkg::MASK_FE_D) == 8'h00)
		else $error("unused front-end D bits stored");
	a_act_hold: assert property (!cycle_start |=> st_r.act == $past(st_r.act))
		else $error("active config changed outside cycle start");
	a_xy_write: assert property (wr_acc && paddr == tsxyg_pkg::OFS_XY |=>
			st_r.cfg.xy == ($past(wbyte) & tsxyg_pkg::MASK_XY))
		else $error("XY config write lost");
	a_unmapped_err: assert property (setup_ph && paddr > tsxyg_pkg::OFS_STATUS |=>
			pslverr && prdata == 32'h0000_0000)
		else $error("unmapped address not refused");

	c_settle_done: cover property (cycle_start ##1 settle_busy [*3] ##[1:1000] conv_start);
	c_gesture: cover property (gest_out_valid && gest_out.multi != 3'h0);
	c_palm: cover property (palm_detect && st_r.act.xy[3] && xy_in_valid);
	c_unmapped: cover property (psel && penable && pslverr);

endmodule : tsxyg_top
`default_nettype wire

// >>> dv/test_touch_sense_xy_gesture_config.sv
`timescale 1ns/100ps
`default_nettype none
module test_touch_sense_xy_gesture_config;
	localparam int unsigned L_LONG  = 40;
	localparam int unsigned L_MID   = 20;
	localparam int unsigned L_SHORT = 10;

	logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]             paddr;
	logic [31:0]            pwdata, prdata, rng;
	logic                   cycle_start, settle_busy, conv_start;
	logic [3:0]             trip_level_code;
	logic [2:0]             charge_phase_length, transfer_phase_length;
	logic                   xy_in_valid, palm_detect, xy_out_valid;
	logic [15:0]            xy_rx_pos, xy_tx_pos, span_x, span_y;
	tsxyg_pkg::tsxyg_xy_t   xy_out, e_xy;
	logic                   gest_in_valid, gest_out_valid;
	tsxyg_pkg::tsxyg_gest_t gest_in, gest_out, e_gs;
	logic [32:0]            q_ap[$];
	logic [26:0]            q_cv[$];
	tsxyg_pkg::tsxyg_xy_t   q_xy[$];
	tsxyg_pkg::tsxyg_gest_t q_gs[$];
	logic [7:0]             sh [5];
	logic [7:0]             msk [5];
	logic [7:0]             act_xy, act_one, act_multi;
	logic [32:0]            ea;
	logic [26:0]            ecv;
	logic [8:0]             en;
	int                     n_mismatch, n_compared, cnt, i, j;

	tsxyg_top #(.SETTLE_LONG_CYC(L_LONG), .SETTLE_MID_CYC(L_MID), .SETTLE_SHORT_CYC(L_SHORT))
	u_tsxyg_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cycle_start(cycle_start), .settle_busy(settle_busy),
		.conv_start(conv_start), .trip_level_code(trip_level_code),
		.charge_phase_length(charge_phase_length),
		.transfer_phase_length(transfer_phase_length), .xy_in_valid(xy_in_valid),
		.xy_rx_pos(xy_rx_pos), .xy_tx_pos(xy_tx_pos), .span_x(span_x), .span_y(span_y),
		.palm_detect(palm_detect), .xy_out_valid(xy_out_valid), .xy_out(xy_out),
		.gest_in_valid(gest_in_valid), .gest_in(gest_in), .gest_out_valid(gest_out_valid),
		.gest_out(gest_out));

	always #10 pclk = ~pclk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs

	function automatic int unsigned len_of(input logic [1:0] c);
		return (c == 2'b01) ? L_MID : (c == 2'b10) ? L_SHORT : L_LONG;
	endfunction : len_of

	function automatic tsxyg_pkg::tsxyg_xy_t map_xy(input logic [7:0] c,
		input logic [15:0] rx, tx, sx, sy);
		logic [15:0] x;
		logic [15:0] y;
		x = c[tsxyg_pkg::SWAP_BIT] ? tx : rx;
		y = c[tsxyg_pkg::SWAP_BIT] ? rx : tx;
		if (c[tsxyg_pkg::FLIPX_BIT]) x = (x > sx) ? 16'h0000 : sx - x;
		if (c[tsxyg_pkg::FLIPY_BIT]) y = (y > sy) ? 16'h0000 : sy - y;
		return {x, y};
	endfunction : map_xy

	task automatic note(input logic [63:0] e, input logic [63:0] g);
		n_compared++;
		if (e !== g) begin
			n_mismatch++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : note

	task automatic cmp_apb(input logic [32:0] e, input logic [32:0] g);
		note(64'(e), 64'(g));
	endtask : cmp_apb

	task automatic cmp_conv(input logic [26:0] e, input logic [26:0] g);
		note(64'(e), 64'(g));
	endtask : cmp_conv

	task automatic cmp_xy(input tsxyg_pkg::tsxyg_xy_t e, input tsxyg_pkg::tsxyg_xy_t g);
		note(64'(e), 64'(g));
	endtask : cmp_xy

	task automatic cmp_gs(input tsxyg_pkg::tsxyg_gest_t e, input tsxyg_pkg::tsxyg_gest_t g);
		note(64'(e), 64'(g));
	endtask : cmp_gs

	// Each transfer leaves one idle cycle behind it, so psel never changes twice in a step.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int  r;
		logic ok;
		r = a >> 2;
		ok = (a[1:0] == 2'b00) && (a <= tsxyg_pkg::OFS_STATUS);
		if (w && ok && r < 5) sh[r] = d[7:0] & msk[r];
		q_ap.push_back(!ok ? {1'b1, 32'h0000_0000} : {25'h0, (r < 5) ? sh[r] : 8'h00});
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the answer.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic start_cycle(input bit expect_it);
		@(posedge pclk);
		cycle_start <= 1'b1;
		if (expect_it) q_cv.push_back({16'(len_of(sh[0][7:6])), sh[0][3:0], sh[1][6:4],
			sh[1][2:0], 1'b0});
		act_xy = sh[2];
		act_one = sh[3];
		act_multi = sh[4];
		@(posedge pclk);
		cycle_start <= 1'b0;
	endtask : start_cycle

	task automatic wait_conv;
		int k;
		k = 0;
		while (q_cv.size() != 0 && k < 300) begin
			@(posedge pclk);
			k++;
		end
		if (q_cv.size() != 0) note(64'h0, 64'h1);
	endtask : wait_conv

	task automatic send_xy(input logic palm);
		logic [15:0] rx, tx;
		rng = xs(rng);
		rx = rng[15:0] >> rng[16];
		tx = rng[31:16] >> rng[17];
		rng = xs(rng);
		if (!(palm && act_xy[tsxyg_pkg::PALM_BIT])) q_xy.push_back(map_xy(act_xy, rx, tx,
			rng[15:0] | 16'h8000, rng[31:16] | 16'h8000));
		@(posedge pclk);
		xy_in_valid <= 1'b1;
		xy_rx_pos <= rx;
		xy_tx_pos <= tx;
		span_x <= rng[15:0] | 16'h8000;
		span_y <= rng[31:16] | 16'h8000;
		palm_detect <= palm;
	endtask : send_xy

	task automatic send_gs(input tsxyg_pkg::tsxyg_gest_t g);
		if ((g & {act_one[5:0], act_multi[2:0]}) != 9'h000)
			q_gs.push_back(g & {act_one[5:0], act_multi[2:0]});
		@(posedge pclk);
		gest_in_valid <= 1'b1;
		gest_in <= g;
	endtask : send_gs

	task automatic close_out;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out

	// Results are judged at the edge that samples them, before that edge's updates land.
	always @(posedge pclk) begin
		if (presetn === 1'b1) begin
			if (psel && penable && pready) begin
				ea = (q_ap.size() != 0) ? q_ap.pop_front() : 'x;
				if (pwrite) ea[31:0] = 32'h0000_0000;
				cmp_apb(ea, {pslverr, pwrite ? 32'h0000_0000 : prdata});
			end
			// The count is read before this edge adds to it, so it equals the edges
			// from the start edge to the edge that launched the pulse.
			if (conv_start) begin
				ecv = (q_cv.size() != 0) ? q_cv.pop_front() : 'x;
				cmp_conv(ecv, {16'(cnt), trip_level_code, charge_phase_length,
					transfer_phase_length, settle_busy});
			end
			cnt = cycle_start ? 0 : cnt + 1;
			if (xy_out_valid) begin
				e_xy = (q_xy.size() != 0) ? q_xy.pop_front() : 'x;
				cmp_xy(e_xy, xy_out);
			end
			if (gest_out_valid) begin
				e_gs = (q_gs.size() != 0) ? q_gs.pop_front() : 'x;
				cmp_gs(e_gs, gest_out);
			end
		end
	end

	// Twenty thousand cycles, more than twenty-five times what the tests take.
	initial begin
		#400000;
		n_mismatch++;
		$display("watchdog expired");
		close_out();
	end

	initial begin
		{pclk, presetn, psel, penable, pwrite, cycle_start} = 6'h00;
		{xy_in_valid, palm_detect, gest_in_valid} = 3'h0;
		{paddr, pwdata, xy_rx_pos, xy_tx_pos, span_x, span_y, gest_in} = '0;
		{act_xy, act_one, act_multi, n_mismatch, n_compared, cnt} = '0;
		sh = '{default: 8'h00};
		msk = '{tsxyg_pkg::MASK_FE_C, tsxyg_pkg::MASK_FE_D, tsxyg_pkg::MASK_XY,
			tsxyg_pkg::MASK_ONE, tsxyg_pkg::MASK_MULTI};
		rng = 32'h0000_757D;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 6; i++) apb(1'b0, 8'(i * 4), 32'h0000_0000);
		for (i = 0; i < 5; i++) begin
			apb(1'b1, 8'(i * 4), 32'hFFFF_FFFF);
			apb(1'b0, 8'(i * 4), 32'h0000_0000);
		end
		apb(1'b1, tsxyg_pkg::OFS_STATUS, 32'hFFFF_FFFF);
		apb(1'b1, 8'h18, 32'hFFFF_FFFF);
		apb(1'b0, 8'h18, 32'h0000_0000);
		apb(1'b0, 8'h02, 32'h0000_0000);
		apb(1'b0, 8'hFC, 32'h0000_0000);
		$display("test registers done");
		for (i = 0; i < 4; i++) begin
			rng = xs(rng);
			apb(1'b1, tsxyg_pkg::OFS_FE_C, {24'h0, 2'(i), rng[5:0]});
			apb(1'b1, tsxyg_pkg::OFS_FE_D, rng);
			start_cycle(1'b1);
			apb(1'b1, tsxyg_pkg::OFS_FE_C, {24'h0, rng[15:8]});
			apb(1'b1, tsxyg_pkg::OFS_FE_D, {24'h0, ~rng[7:0]});
			wait_conv();
		end
		start_cycle(1'b0);
		repeat (5) @(posedge pclk);
		start_cycle(1'b1);
		wait_conv();
		$display("test settle done");
		for (i = 0; i < 16; i++) begin
			apb(1'b1, tsxyg_pkg::OFS_XY, 32'(i));
			start_cycle(1'b1);
			for (j = 0; j < 4; j++) send_xy(j[0]);
			@(posedge pclk);
			xy_in_valid <= 1'b0;
			wait_conv();
		end
		$display("test xy done");
		for (i = 0; i < 11; i++) begin
			rng = xs(rng);
			en = (i < 9) ? 9'(1 << i) : (i == 9) ? 9'h000 : rng[8:0];
			apb(1'b1, tsxyg_pkg::OFS_ONE, 32'(en[8:3]));
			apb(1'b1, tsxyg_pkg::OFS_MULTI, 32'(en[2:0]));
			start_cycle(1'b1);
			apb(1'b1, tsxyg_pkg::OFS_ONE, 32'(~en[8:3]));
			apb(1'b1, tsxyg_pkg::OFS_MULTI, 32'(~en[2:0]));
			for (j = 0; j < 3; j++) begin
				rng = xs(rng);
				send_gs((j == 0) ? 9'h1FF : rng[8:0]);
			end
			@(posedge pclk);
			gest_in_valid <= 1'b0;
			wait_conv();
		end
		$display("test gestures done");
		repeat (4) @(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		sh = '{default: 8'h00};
		for (i = 0; i < 6; i++) apb(1'b0, 8'(i * 4), 32'h0000_0000);
		repeat (4) @(posedge pclk);
		note(64'h0, 64'(q_ap.size() + q_cv.size() + q_xy.size() + q_gs.size()));
		$display("test second reset done");
		close_out();
	end
endmodule : test_touch_sense_xy_gesture_config
`default_nettype wire
